// *** bench/scra_host.sv ***
`timescale 1ns/1ns
module scra_host (
   input wire logic clk_in,
   input wire logic miso_in,
   output logic sclk_out,
   output logic mosi_out,
   output logic chip_select_n_out
);
   initial begin
      sclk_out = 1'b0;
      mosi_out = 1'b0;
      chip_select_n_out = 1'b1;
   end
   // phases of 5 clocks keep clear of the 2-flop synchronisers; no other handshake is used
   task automatic xfer(input logic [15:0] tx, input int nbits, output logic [15:0] rx);
      rx = 16'h0000;
      chip_select_n_out <= 1'b0;
      repeat (6) @(posedge clk_in);
      for (int i = 15; i > 15 - nbits; i--) begin
         mosi_out <= tx[i];
         repeat (5) @(posedge clk_in);
         sclk_out <= 1'b1;
         rx = {rx[14:0], miso_in};
         repeat (5) @(posedge clk_in);
         sclk_out <= 1'b0;
      end
      repeat (5) @(posedge clk_in);
      chip_select_n_out <= 1'b1;
      // the released data line must not keep its last bit
      mosi_out <= ~mosi_out;
      repeat (8) @(posedge clk_in);
   endtask : xfer
endmodule : scra_host

// *** bench/scra_properties.sv ***
`timescale 1ns/1ns
module scra_properties
   import scra_pkg::*;
(
   input wire logic clk_in,
   input wire logic reset_in,
   input wire logic chip_select_n_in,
   input wire logic [FAULT_REGS-1:0][6:0] fault_event_in,
   input wire logic miso_out,
   input wire logic miso_oe_n_out,
   input wire logic [CFG_COUNT-1:0][7:0] config_bank_out,
   input wire logic [CTL_COUNT-1:0][7:0] control_bank_out,
   input wire logic [STS_COUNT-1:0][7:0] status_bank_out,
   input wire logic [DRV_COUNT-1:0] retry_enable_out,
   input wire logic [DRV_COUNT-1:0] sink_enable_out,
   input wire logic [DRV_COUNT-1:0] inrush_delay_out,
   input wire logic [DRV_COUNT-1:0][1:0] pwm_freq_out
);
   logic [20:0] faults_w;
   assign faults_w = {status_bank_out[2][6:0], status_bank_out[1][6:0], status_bank_out[0][6:0]};
   // dflt selects reset values, otherwise absent bits must be zero; status bit 7 is derived
   function automatic logic fits(input logic [CFG_COUNT-1:0][7:0] c, input logic [CTL_COUNT-1:0][7:0] t,
                                 input logic [STS_COUNT-1:0][7:0] s, input logic dflt);
      logic ok;
      ok = 1'b1;
      for (int i = 0; i < CFG_COUNT; i++)
         ok &= dflt ? c[i] == CFG_RESET[i] : (c[i] & ~CFG_EXIST[i]) == 8'h00;
      for (int i = 0; i < CTL_COUNT; i++)
         ok &= dflt ? t[i] == CTL_RESET[i] : (t[i] & ~CTL_EXIST[i]) == 8'h00;
      for (int i = 0; i < STS_COUNT; i++)
         ok &= dflt ? s[i] == STS_RESET[i] : (s[i] & ~(STS_EXIST[i] | 8'h80)) == 8'h00;
      return ok;
   endfunction : fits
   function automatic logic drv_ok(input logic [CFG_COUNT-1:0][7:0] c, input logic [4:0] r, input logic [4:0] k,
                                   input logic [4:0] n, input logic [4:0][1:0] p);
      logic ok;
      ok = 1'b1;
      for (int i = 0; i < DRV_COUNT; i++)
         ok &= {r[i], k[i], n[i], p[i]} == {c[DRV_REG[i]][7], c[DRV_REG[i]][4], c[DRV_REG[i]][3], c[DRV_REG[i]][1:0]};
      return ok;
   endfunction : drv_ok
   function automatic logic sts_ok(input logic [STS_COUNT-1:0][7:0] s);
      logic ok;
      ok = s[3][7] == (s[0][7] | s[1][7] | s[2][7]);
      for (int i = 0; i < FAULT_REGS; i++)
         ok &= s[i][7] == |s[i][6:0];
      return ok;
   endfunction : sts_ok
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (reset_in);
   property p_reset_defaults;
      $fell(reset_in) |-> fits(config_bank_out, control_bank_out, status_bank_out, 1'b1) && miso_oe_n_out;
   endproperty
   a_reset_defaults: assert property (p_reset_defaults) else $error("defaults wrong after reset");
   property p_absent_zero;
      fits(config_bank_out, control_bank_out, status_bank_out, 1'b0);
   endproperty
   a_absent_zero: assert property (p_absent_zero) else $error("absent bit set");
   property p_oe_idle;
      chip_select_n_in [*7] |-> miso_oe_n_out && !miso_out;
   endproperty
   a_oe_idle: assert property (p_oe_idle) else $error("serial output driven while deselected");
   property p_oe_frame;
      !chip_select_n_in [*7] |-> !miso_oe_n_out;
   endproperty
   a_oe_frame: assert property (p_oe_frame) else $error("serial output not enabled in frame");
   property p_bank_after_cs;
      !$stable(config_bank_out) || !$stable(control_bank_out) |-> chip_select_n_in && $past(chip_select_n_in, 3);
   endproperty
   a_bank_after_cs: assert property (p_bank_after_cs) else $error("bank changed inside a frame");
   property p_drv_fields;
      $stable(config_bank_out) |->
         drv_ok(config_bank_out, retry_enable_out, sink_enable_out, inrush_delay_out, pwm_freq_out);
   endproperty
   a_drv_fields: assert property (p_drv_fields) else $error("driver fields differ from config");
   property p_sts_any;
      sts_ok(status_bank_out);
   endproperty
   a_sts_any: assert property (p_sts_any) else $error("fault summary bit wrong");
   property p_fault_set;
      fault_event_in != 21'h0 |-> ##2 (faults_w & $past(fault_event_in, 2)) == $past(fault_event_in, 2);
   endproperty
   a_fault_set: assert property (p_fault_set) else $error("fault event not recorded");
   property p_fault_sticky;
      ($past(faults_w) & ~faults_w) != 21'h0 |-> chip_select_n_in && $past(chip_select_n_in, 4);
   endproperty
   a_fault_sticky: assert property (p_fault_sticky) else $error("fault bit dropped without a write");
endmodule : scra_properties

bind scra_top scra_properties scra_properties_inst (.clk_in(clk_in), .reset_in(reset_in),
   .chip_select_n_in(chip_select_n_in), .fault_event_in(fault_event_in), .miso_out(miso_out),
   .miso_oe_n_out(miso_oe_n_out), .config_bank_out(config_bank_out), .control_bank_out(control_bank_out),
   .status_bank_out(status_bank_out), .retry_enable_out(retry_enable_out), .sink_enable_out(sink_enable_out),
   .inrush_delay_out(inrush_delay_out), .pwm_freq_out(pwm_freq_out));

// *** bench/spi_command_register_access_tb.sv ***
`timescale 1ns/1ns
module spi_command_register_access_tb
   import scra_pkg::*;
;
   typedef struct {string name; logic [15:0] val;} scra_note_t;
   logic clk_in, reset_in, sclk, mosi, cs_n, miso, oe_n, self_test, summary;
   logic [FAULT_REGS-1:0][6:0] fault_event;
   logic [CFG_COUNT-1:0][7:0] cfg_bank;
   logic [CTL_COUNT-1:0][7:0] ctl_bank;
   logic [STS_COUNT-1:0][7:0] sts_bank;
   logic [DRV_COUNT-1:0] retry, sink, inrush;
   logic [DRV_COUNT-1:0][1:0] pwm;
   scra_note_t exp_q[$];
   logic [15:0] seen_q[$];
   logic [15:0] rx, pend, w;
   logic [20:0] f;
   scra_byte_t wr [CFG_COUNT];
   scra_byte_t d, e;
   int error_cnt = 0;
   int checks_done = 0;
   int cycles = 0;
   scra_top scra_top_inst (.clk_in(clk_in), .reset_in(reset_in), .sclk_in(sclk), .mosi_in(mosi),
      .chip_select_n_in(cs_n), .fault_event_in(fault_event), .miso_out(miso), .miso_oe_n_out(oe_n),
      .config_bank_out(cfg_bank), .control_bank_out(ctl_bank), .status_bank_out(sts_bank),
      .retry_enable_out(retry), .sink_enable_out(sink), .inrush_delay_out(inrush), .pwm_freq_out(pwm),
      .self_test_mode_out(self_test), .fault_summary_out(summary));
   scra_host scra_host_inst (.clk_in(clk_in), .miso_in(miso), .sclk_out(sclk), .mosi_out(mosi),
      .chip_select_n_out(cs_n));
   initial begin
      clk_in = 1'b0;
      forever #20 clk_in = ~clk_in;
   end
   task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask : check
   task automatic note(string name, logic [15:0] exp, logic [15:0] seen);
      exp_q.push_back('{name, exp});
      seen_q.push_back(seen);
   endtask : note
   initial begin : watch
      scra_note_t n;
      // polled at the falling edge so every note taken at a rising edge is already queued
      forever begin
         @(negedge clk_in);
         while (seen_q.size() > 0) begin
            n = exp_q.pop_front();
            check(n.name, seen_q.pop_front(), n.val);
         end
      end
   end
   // every frame collects the reply that the previous frame left behind
   task automatic send(logic [15:0] word, logic [15:0] next);
      scra_host_inst.xfer(word, 16, rx);
      note("reply", pend, rx);
      pend = next;
   endtask : send
   task automatic wr_rd(logic [3:0] wc, logic [3:0] a, scra_byte_t dt, scra_byte_t rb);
      send({wc, a, dt}, {wc, a, dt});
      send({wc - 4'h1, a, 8'($urandom)}, {wc - 4'h1, a, rb});
   endtask : wr_rd
   task automatic cfg_match();
      for (int i = 0; i < CFG_COUNT; i++)
         note("cfg", 16'(wr[i]), 16'(cfg_bank[i]));
   endtask : cfg_match
   task automatic defaults();
      for (int i = 0; i < CFG_COUNT; i++)
         note("cfg", 16'(CFG_RESET[i]), 16'(cfg_bank[i]));
      for (int i = 0; i < CTL_COUNT; i++)
         note("ctl", 16'(CTL_RESET[i]), 16'(ctl_bank[i]));
      for (int i = 0; i < STS_COUNT; i++)
         note("sts", 16'(STS_RESET[i]), 16'(sts_bank[i]));
   endtask : defaults
   task automatic results();
      $display("checks %0d mismatches %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : results
   always @(posedge clk_in) begin
      cycles++;
      if (cycles == 40000) begin
         error_cnt++;
         results();
      end
   end
   initial begin
      reset_in = 1'b1;
      fault_event = '0;
      pend = 16'h0000;
      void'($urandom(32'h46DDA8BE));
      repeat (12) @(posedge clk_in);
      reset_in <= 1'b0;
      repeat (4) @(posedge clk_in);
      defaults();
      for (int a = 0; a < CFG_COUNT; a++) begin
         wr[a] = 8'($urandom) & CFG_EXIST[a];
         wr_rd(CMD_WRITE_CFG, 4'(a), wr[a] | ~CFG_EXIST[a], wr[a]);
      end
      cfg_match();
      for (int i = 0; i < DRV_COUNT; i++) begin
         d = wr[DRV_REG[i]];
         note("drv", 16'({d[7], d[4], d[3], d[1:0]}), 16'({retry[i], sink[i], inrush[i], pwm[i]}));
      end
      for (int a = CFG_COUNT; a < 16; a++)
         wr_rd(CMD_WRITE_CFG, 4'(a), 8'($urandom), 8'h00);
      scra_host_inst.xfer({CMD_WRITE_CFG, 4'h0, ~wr[0]}, 8, rx);
      cfg_match();
      for (int c = 7; c < 16; c++)
         send({4'(c), 4'h0, ~wr[0]}, 16'h0000);
      cfg_match();
      w = 16'($urandom) & 16'h0FFF;
      send(w, {CMD_LOOP_REPLY, w[11:0]});
      for (int a = 0; a < CTL_COUNT; a++) begin
         d = 8'($urandom) & (a == CTL_OTHER_IDX ? 8'hBE : 8'hFF);
         wr_rd(CMD_WRITE_CTL, 4'(a), d, d & CTL_EXIST[a]);
         note("ctl", 16'(d & CTL_EXIST[a]), 16'(ctl_bank[a]));
      end
      wr_rd(CMD_WRITE_CTL, 4'h4 | 4'($urandom), 8'($urandom), 8'h00);
      wr_rd(CMD_WRITE_STS, 4'h4 | 4'($urandom), 8'($urandom), 8'h00);
      f = 21'($urandom) | 21'h1;
      fault_event <= f;
      @(posedge clk_in);
      fault_event <= '0;
      repeat (4) @(posedge clk_in);
      for (int i = 0; i < FAULT_REGS; i++)
         note("sts", 16'({|f[7*i+:7], f[7*i+:7]}), 16'(sts_bank[i]));
      note("summary", 16'(1'b1), 16'(summary));
      d = 8'($urandom);
      e = {1'b0, f[6:0] & d[6:0]};
      wr_rd(CMD_WRITE_STS, 4'h0, d, {|e, e[6:0]});
      note("sts", 16'({|e, e[6:0]}), 16'(sts_bank[0]));
      send({CMD_WRITE_CTL, 4'h1, 8'h40}, {CMD_WRITE_CTL, 4'h1, 8'h40});
      note("self", 16'(1'b1), 16'(self_test));
      d = 8'($urandom) & 8'h7F;
      wr_rd(CMD_WRITE_STS, 4'h1, d, {|d, d[6:0]});
      note("sts", 16'({|d, d[6:0]}), 16'(sts_bank[1]));
      note("summary", 16'(|{e, d, f[20:14]}), 16'(summary));
      send({CMD_WRITE_CTL, 4'h1, 8'h01}, 16'h0000);
      defaults();
      send({CMD_READ_CFG, 4'h8, 8'h00}, {CMD_READ_CFG, 4'h8, CFG_RESET[8]});
      send(16'h0000, 16'h7000);
      while (seen_q.size() != 0)
         @(posedge clk_in);
      @(posedge clk_in);
      results();
   end
endmodule : spi_command_register_access_tb

// *** rtl/scra_pkg.sv ***
package scra_pkg;
   localparam int FRAME_BITS = 16;
   localparam int CNT_W = 5;
   localparam logic [CNT_W-1:0] CNT_FULL = 5'h10;
   localparam logic [CNT_W-1:0] CNT_SAT = 5'h1F;
   localparam int CODE_MSB = 15;
   localparam int CODE_LSB = 12;
   localparam int ADDR_MSB = 11;
   localparam int ADDR_LSB = 8;
   localparam int DATA_MSB = 7;

   localparam logic [3:0] CMD_LOOP_CHECK = 4'h0;
   localparam logic [3:0] CMD_READ_CFG = 4'h1;
   localparam logic [3:0] CMD_WRITE_CFG = 4'h2;
   localparam logic [3:0] CMD_READ_STS = 4'h3;
   localparam logic [3:0] CMD_WRITE_STS = 4'h4;
   localparam logic [3:0] CMD_READ_CTL = 4'h5;
   localparam logic [3:0] CMD_WRITE_CTL = 4'h6;
   localparam logic [3:0] CMD_LOOP_REPLY = 4'h7;

   typedef logic [7:0] scra_byte_t;

   localparam int CFG_COUNT = 9;
   localparam int CTL_COUNT = 4;
   localparam int STS_COUNT = 4;
   localparam int FAULT_REGS = 3;
   localparam logic [3:0] CFG_LAST = 4'h8;
   localparam logic [3:0] CTL_LAST = 4'h3;
   localparam logic [3:0] STS_LAST = 4'h3;

   // configuration bank: injector 1/2, relay 1/2, tach, lamp, battery switch, heater, ignition 1
   localparam scra_byte_t CFG_RESET [CFG_COUNT] = '{8'h10, 8'h10, 8'h18, 8'h10, 8'h01, 8'h18, 8'h00, 8'h10, 8'h80};
   localparam scra_byte_t CFG_EXIST [CFG_COUNT] = '{8'h9F, 8'h9F, 8'h9F, 8'hDF, 8'hFF, 8'h9B, 8'h83, 8'hD7, 8'hD7};
   // control bank: main on/off, other on/off, two duty registers
   localparam scra_byte_t CTL_RESET [CTL_COUNT] = '{8'h00, 8'h12, 8'h00, 8'h00};
   localparam scra_byte_t CTL_EXIST [CTL_COUNT] = '{8'hFF, 8'hD7, 8'h7F, 8'h7F};
   // status bank: bit 7 is derived, the last register only carries the system summary
   localparam scra_byte_t STS_RESET [STS_COUNT] = '{8'h00, 8'h00, 8'h00, 8'h00};
   localparam scra_byte_t STS_EXIST [STS_COUNT] = '{8'h7F, 8'h7F, 8'h7F, 8'h00};

   localparam int CTL_OTHER_IDX = 1;
   localparam int SELF_TEST_BIT = 6;
   localparam int SOFT_RESET_BIT = 0;
   localparam int STS_SUMMARY_IDX = 3;
   localparam int ANY_FAULT_BIT = 7;

   // low-side drivers sharing the common configuration layout
   localparam int DRV_COUNT = 5;
   localparam int DRV_REG [DRV_COUNT] = '{0, 1, 2, 3, 5};
   localparam int RETRY_BIT = 7;
   localparam int SINK_BIT = 4;
   localparam int INRUSH_BIT = 3;
   localparam int PWMF_MSB = 1;
   localparam int PWMF_LSB = 0;

   typedef enum logic [1:0] {
      SCRA_IDLE = 2'b01,
      SCRA_ACTIVE = 2'b10
   } scra_state_t;
endpackage : scra_pkg

// *** rtl/scra_shift.sv ***
`timescale 1ns/1ns
module scra_shift
   import scra_pkg::*;
(
   input wire logic clk_in,
   input wire logic reset_in,
   input wire logic sclk_in,
   input wire logic mosi_in,
   input wire logic chip_select_n_in,
   input wire logic [FRAME_BITS-1:0] reply_word_in,
   output logic frame_valid_out,
   output logic [FRAME_BITS-1:0] frame_word_out,
   output logic miso_out,
   output logic miso_oe_n_out
);
   logic [2:0] sync1_q, sync2_q;
   logic sclk_prev_q, cs_prev_q;
   scra_state_t state_q, state_d;
   logic [CNT_W-1:0] cnt_q, cnt_d;
   logic [FRAME_BITS-1:0] rx_q, rx_d, tx_q, tx_d, word_q, word_d;
   logic valid_q, valid_d, miso_q, miso_d, oe_n_q, oe_n_d;
   logic sclk_rise, sclk_fall, cs_fall, cs_rise;

   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         sync1_q <= 3'h7;
         sync2_q <= 3'h7;
         sclk_prev_q <= 1'b1;
         cs_prev_q <= 1'b1;
      end else begin
         sync1_q <= {chip_select_n_in, mosi_in, sclk_in};
         sync2_q <= sync1_q;
         sclk_prev_q <= sync2_q[0];
         cs_prev_q <= sync2_q[2];
      end
   end

   always_comb begin
      sclk_rise = sync2_q[0] & ~sclk_prev_q;
      sclk_fall = ~sync2_q[0] & sclk_prev_q;
      cs_fall = ~sync2_q[2] & cs_prev_q;
      cs_rise = sync2_q[2] & ~cs_prev_q;
      state_d = state_q;
      cnt_d = cnt_q;
      rx_d = rx_q;
      tx_d = tx_q;
      word_d = word_q;
      valid_d = 1'b0;
      miso_d = miso_q;
      oe_n_d = oe_n_q;
      case (state_q)
         SCRA_IDLE: begin
            // frames are taken whenever select falls, no other handshake
            if (cs_fall) begin
               state_d = SCRA_ACTIVE;
               cnt_d = '0;
               tx_d = reply_word_in;
               miso_d = reply_word_in[FRAME_BITS-1];
               oe_n_d = 1'b0;
            end
         end
         SCRA_ACTIVE: begin
            if (cs_rise) begin
               state_d = SCRA_IDLE;
               miso_d = 1'b0;
               oe_n_d = 1'b1;
               // short or long frames are dropped unexecuted
               if (cnt_q == CNT_FULL) begin
                  valid_d = 1'b1;
                  word_d = rx_q;
               end
            end else begin
               if (sclk_rise) begin
                  rx_d = {rx_q[FRAME_BITS-2:0], sync2_q[1]};
                  if (cnt_q != CNT_SAT) begin
                     cnt_d = cnt_q + 5'h01;
                  end
               end
               if (sclk_fall) begin
                  tx_d = {tx_q[FRAME_BITS-2:0], 1'b0};
                  miso_d = tx_q[FRAME_BITS-2];
               end
            end
         end
         default: begin
            state_d = SCRA_IDLE;
            oe_n_d = 1'b1;
         end
      endcase
   end

   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         state_q <= SCRA_IDLE;
         cnt_q <= '0;
         rx_q <= '0;
         tx_q <= '0;
         word_q <= '0;
         valid_q <= 1'b0;
         miso_q <= 1'b0;
         oe_n_q <= 1'b1;
      end else begin
         state_q <= state_d;
         cnt_q <= cnt_d;
         rx_q <= rx_d;
         tx_q <= tx_d;
         word_q <= word_d;
         valid_q <= valid_d;
         miso_q <= miso_d;
         oe_n_q <= oe_n_d;
      end
   end

   assign frame_valid_out = valid_q;
   assign frame_word_out = word_q;
   assign miso_out = miso_q;
   assign miso_oe_n_out = oe_n_q;
endmodule : scra_shift

// *** rtl/scra_top.sv ***
`timescale 1ns/1ns
// What this block does
// - frames are 16 bits: 4-bit command code on top, 12-bit payload below.
// - codes 0 to 6 are decoded; code 7 heads the loop-check reply.
// - registers are 8 bits; bits 11..8 address, bits 7..0 carry data.
// - writes use the same frame's data; read data returns in the next frame.
// - frames are accepted at any time, with no extra synchronisation.
// - a command executes only when chip select rises after a full frame.
// - loop-check reply returns exactly the payload bits the host sent.
// - every reset, hardware or software, restores documented default values.
// - driver configuration holds retry, sink enable, inrush delay and PWM frequency fields.
// - a set fault bit stays until host clear or any reset.
// - host writes only clear status bits unless self-test mode is set.
// - non-existent bits read zero and ignore writes.
// - status bit 7 ORs its faults; a summary bit ORs all of those.
module scra_top
   import scra_pkg::*;
(
   input wire logic clk_in,
   input wire logic reset_in,
   input wire logic sclk_in,
   input wire logic mosi_in,
   input wire logic chip_select_n_in,
   input wire logic [FAULT_REGS-1:0][6:0] fault_event_in,
   output logic miso_out,
   output logic miso_oe_n_out,
   output logic [CFG_COUNT-1:0][7:0] config_bank_out,
   output logic [CTL_COUNT-1:0][7:0] control_bank_out,
   output logic [STS_COUNT-1:0][7:0] status_bank_out,
   output logic [DRV_COUNT-1:0] retry_enable_out,
   output logic [DRV_COUNT-1:0] sink_enable_out,
   output logic [DRV_COUNT-1:0] inrush_delay_out,
   output logic [DRV_COUNT-1:0][1:0] pwm_freq_out,
   output logic self_test_mode_out,
   output logic fault_summary_out
);
   logic frame_valid;
   logic [FRAME_BITS-1:0] frame_word;
   logic [3:0] cmd_code, reg_addr;
   logic [7:0] wr_data;
   scra_byte_t cfg_q [CFG_COUNT];
   scra_byte_t cfg_d [CFG_COUNT];
   scra_byte_t ctl_q [CTL_COUNT];
   scra_byte_t ctl_d [CTL_COUNT];
   scra_byte_t sts_q [STS_COUNT];
   scra_byte_t sts_d [STS_COUNT];
   scra_byte_t sts_view [STS_COUNT];
   scra_byte_t view_q [STS_COUNT];
   logic [FRAME_BITS-1:0] reply_q, reply_d;
   logic soft_q, soft_d;
   logic self_test;
   logic [7:0] rd_data;

   scra_shift u_shift (
      .clk_in(clk_in),
      .reset_in(reset_in),
      .sclk_in(sclk_in),
      .mosi_in(mosi_in),
      .chip_select_n_in(chip_select_n_in),
      .reply_word_in(reply_q),
      .frame_valid_out(frame_valid),
      .frame_word_out(frame_word),
      .miso_out(miso_out),
      .miso_oe_n_out(miso_oe_n_out)
   );

   assign cmd_code = frame_word[CODE_MSB:CODE_LSB];
   assign reg_addr = frame_word[ADDR_MSB:ADDR_LSB];
   assign wr_data = frame_word[DATA_MSB:0];
   assign self_test = ctl_q[CTL_OTHER_IDX][SELF_TEST_BIT];

   // derived any-fault bits are recomputed every cycle from sts_q, then registered in view_q, so they cannot go stale
   always_comb begin
      for (int i = 0; i < STS_COUNT; i++) begin
         sts_view[i] = sts_q[i];
      end
      for (int i = 0; i < FAULT_REGS; i++) begin
         sts_view[i][ANY_FAULT_BIT] = |sts_q[i][6:0];
      end
      sts_view[STS_SUMMARY_IDX][ANY_FAULT_BIT] = 1'b0;
      for (int i = 0; i < FAULT_REGS; i++) begin
         sts_view[STS_SUMMARY_IDX][ANY_FAULT_BIT] = sts_view[STS_SUMMARY_IDX][ANY_FAULT_BIT] |
            sts_view[i][ANY_FAULT_BIT];
      end
   end

   always_comb begin
      rd_data = 8'h00;
      case (cmd_code)
         CMD_READ_CFG: begin
            if (reg_addr <= CFG_LAST) begin
               rd_data = cfg_q[reg_addr];
            end
         end
         CMD_READ_STS: begin
            if (reg_addr <= STS_LAST) begin
               rd_data = sts_view[reg_addr[1:0]];
            end
         end
         CMD_READ_CTL: begin
            if (reg_addr <= CTL_LAST) begin
               rd_data = ctl_q[reg_addr[1:0]];
            end
         end
         default: rd_data = 8'h00;
      endcase
   end

   always_comb begin
      cfg_d = cfg_q;
      ctl_d = ctl_q;
      sts_d = sts_q;
      reply_d = reply_q;
      soft_d = 1'b0;
      if (soft_q) begin
         cfg_d = CFG_RESET;
         ctl_d = CTL_RESET;
         sts_d = STS_RESET;
         reply_d = '0;
      end else begin
         if (frame_valid) begin
            // reads answer with code, address and data, shifted out during the next frame
            reply_d = {cmd_code, reg_addr, rd_data};
            case (cmd_code)
               CMD_LOOP_CHECK: begin
                  reply_d = {CMD_LOOP_REPLY, frame_word[ADDR_MSB:0]};
               end
               CMD_WRITE_CFG: begin
                  if (reg_addr <= CFG_LAST) begin
                     cfg_d[reg_addr] = wr_data & CFG_EXIST[reg_addr];
                  end
                  reply_d = frame_word;
               end
               CMD_WRITE_CTL: begin
                  if (reg_addr <= CTL_LAST) begin
                     ctl_d[reg_addr[1:0]] = wr_data & CTL_EXIST[reg_addr[1:0]];
                     // the software reset bit never stays set; it triggers one reset cycle
                     if (reg_addr == 4'(CTL_OTHER_IDX) && wr_data[SOFT_RESET_BIT]) begin
                        soft_d = 1'b1;
                     end
                  end
                  reply_d = frame_word;
               end
               CMD_WRITE_STS: begin
                  if (reg_addr <= STS_LAST) begin
                     if (self_test) begin
                        sts_d[reg_addr[1:0]] = wr_data & STS_EXIST[reg_addr[1:0]];
                     end else begin
                        // writing 0 clears a bit, writing 1 leaves it
                        sts_d[reg_addr[1:0]] = sts_q[reg_addr[1:0]] & wr_data &
                           STS_EXIST[reg_addr[1:0]];
                     end
                  end
                  reply_d = frame_word;
               end
               CMD_READ_CFG, CMD_READ_STS, CMD_READ_CTL: begin
                  reply_d = {cmd_code, reg_addr, rd_data};
               end
               default: begin
                  reply_d = '0;
               end
            endcase
         end
         // a fault arriving in the clearing cycle still lands
         for (int i = 0; i < FAULT_REGS; i++) begin
            sts_d[i] = (sts_d[i] | {1'b0, fault_event_in[i]}) & STS_EXIST[i];
         end
      end
   end

   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         cfg_q <= CFG_RESET;
         ctl_q <= CTL_RESET;
         sts_q <= STS_RESET;
         view_q <= STS_RESET;
         reply_q <= '0;
         soft_q <= 1'b0;
      end else begin
         cfg_q <= cfg_d;
         ctl_q <= ctl_d;
         sts_q <= sts_d;
         view_q <= sts_view;
         reply_q <= reply_d;
         soft_q <= soft_d;
      end
   end

   genvar g;
   generate
      for (g = 0; g < DRV_COUNT; g++) begin : g_drv
         assign retry_enable_out[g] = cfg_q[DRV_REG[g]][RETRY_BIT];
         assign sink_enable_out[g] = cfg_q[DRV_REG[g]][SINK_BIT];
         assign inrush_delay_out[g] = cfg_q[DRV_REG[g]][INRUSH_BIT];
         assign pwm_freq_out[g] = cfg_q[DRV_REG[g]][PWMF_MSB:PWMF_LSB];
      end
      for (g = 0; g < CFG_COUNT; g++) begin : g_cfg
         assign config_bank_out[g] = cfg_q[g];
      end
      for (g = 0; g < CTL_COUNT; g++) begin : g_ctl
         assign control_bank_out[g] = ctl_q[g];
      end
      for (g = 0; g < STS_COUNT; g++) begin : g_sts
         assign status_bank_out[g] = view_q[g];
      end
   endgenerate

   assign self_test_mode_out = ctl_q[CTL_OTHER_IDX][SELF_TEST_BIT];
   assign fault_summary_out = view_q[STS_SUMMARY_IDX][ANY_FAULT_BIT];
endmodule : scra_top
